// ### color_i2c_target.sv
/*
 * Two-wire (I2C/SMBus) target port of a four-channel colour sensor.
 * Holds start/stop detection, strap address matching, acknowledge, MSB-first
 * byte transfer, register pointer, 16-bit register writes through a two-entry
 * buffer, register reads, general-call reset, high-speed code and lockup timeout.
 * Assumes: SCL comes from the bus controller and is a clock of its own; the
 * pad logic resolves SDA from O_SDA_OE (drive low) and a pull-up; the system
 * clock is fast enough that a synchronised SCL edge is seen before the next one.
 */
`default_nettype none

module color_i2c_target #(
    parameter int TIMEOUT_CYC = color_i2c_pkg::TIMEOUT_CYCLES,
    parameter int TIMEOUT_W = color_i2c_pkg::TIMEOUT_W,
    parameter int BUF_W = color_i2c_pkg::PTR_W + color_i2c_pkg::REG_W
) (
    // system clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    // bus pins and address strap
    input wire logic I_SCL,
    input wire logic I_SDA,
    output logic O_SDA_O,
    output logic O_SDA_OE,
    input wire logic I_ADDR_PIN,
    // register write stream
    output logic O_WR_VALID,
    input wire logic I_WR_READY,
    output logic [color_i2c_pkg::PTR_W-1:0] O_WR_PTR,
    output logic [color_i2c_pkg::REG_W-1:0] O_WR_DATA,
    // register read
    output logic [color_i2c_pkg::PTR_W-1:0] O_RD_PTR,
    input wire logic [color_i2c_pkg::REG_W-1:0] I_RD_DATA,
    // status
    output logic O_GC_RESET,
    output logic O_HS_MODE
);

    localparam logic [TIMEOUT_W-1:0] TO_LAST = TIMEOUT_W'(TIMEOUT_CYC - 1);
    localparam logic [TIMEOUT_W-1:0] TO_FULL = TIMEOUT_W'(TIMEOUT_CYC);

    // link clock domain: sample on every SCL rise, flag each with a toggle
    logic bit_val = 1'b1;
    logic bit_tgl = 1'b0;

    always_ff @(posedge I_SCL)
    begin
        bit_val <= I_SDA;
        bit_tgl <= ~bit_tgl;
    end

    // system domain synchronisers; bit_val is bundled data, stable until next rise
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    logic addr_m, addr_s, addr_d;
    logic tgl_m, tgl_s, tgl_d;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
            {addr_m, addr_s, addr_d} <= 3'h0;
            {tgl_m, tgl_s, tgl_d} <= 3'h0;
        end
        else
        begin
            {scl_m, scl_s, scl_d} <= {I_SCL, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {I_SDA, sda_m, sda_s};
            {addr_m, addr_s, addr_d} <= {I_ADDR_PIN, addr_m, addr_s};
            {tgl_m, tgl_s, tgl_d} <= {bit_tgl, tgl_m, tgl_s};
        end
    end

    logic start_evt, stop_evt, scl_fall, bit_evt, timeout_evt;

    assign start_evt = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_evt = scl_s & scl_d & ~sda_d & sda_s;
    assign scl_fall = scl_d & ~scl_s;
    assign bit_evt = tgl_s ^ tgl_d;

    // lockup timeout on SCL held low
    logic [TIMEOUT_W-1:0] low_cnt;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N || scl_s)
            low_cnt <= '0;
        else if (low_cnt != TO_FULL)
            low_cnt <= low_cnt + TIMEOUT_W'(1);
    end

    assign timeout_evt = ~scl_s & (low_cnt == TO_LAST);

    // strap sampling: before start, at start, and in the first low phase
    logic strap_idle, strap_start, first_low;
    logic [6:0] own_addr;
    color_i2c_pkg::strap_t strap;

    always_comb
    begin
        if (!strap_idle)
            strap = color_i2c_pkg::STRAP_GND;
        else if (!strap_start)
            strap = color_i2c_pkg::STRAP_SDA;
        else if (!addr_s)
            strap = color_i2c_pkg::STRAP_SCL;
        else
            strap = color_i2c_pkg::STRAP_VDD;
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            strap_idle <= 1'b0;
            strap_start <= 1'b0;
            first_low <= 1'b0;
            own_addr <= color_i2c_pkg::ADDR_GND;
        end
        else if (start_evt)
        begin
            strap_idle <= addr_d;
            strap_start <= addr_s;
            first_low <= 1'b1;
        end
        else if (scl_fall && first_low)
        begin
            first_low <= 1'b0;
            own_addr <= color_i2c_pkg::strap_address(strap);
        end
    end

    // frame state
    color_i2c_pkg::state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg, tx, rd_lo, msb, ptr;
    logic [1:0] byte_idx;
    logic ack_pend, first_rd, sda_oe;
    logic buf_room;

    // byte decode at the eighth bit
    logic [7:0] rx_byte;
    logic byte_end;
    color_i2c_pkg::state_t dec_state;
    logic dec_ack, dec_push, dec_ptr_load, dec_gc, dec_hs, dec_rd_load;

    always_comb
    begin
        rx_byte = {shreg[6:0], bit_val};
        byte_end = bit_evt && (state != color_i2c_pkg::ST_IDLE) && (bit_cnt == color_i2c_pkg::BIT_LAST);
        dec_state = state;
        dec_ack = 1'b0;
        dec_push = 1'b0;
        dec_ptr_load = 1'b0;
        dec_gc = 1'b0;
        dec_hs = 1'b0;
        dec_rd_load = 1'b0;
        if (byte_end)
        begin
            case (state)
                color_i2c_pkg::ST_ADDR:
                begin
                    if (rx_byte[7:1] == own_addr)
                    begin
                        dec_ack = 1'b1;
                        dec_rd_load = rx_byte[0];
                        dec_state = rx_byte[0] ? color_i2c_pkg::ST_READ : color_i2c_pkg::ST_WRITE;
                    end
                    else if (rx_byte == color_i2c_pkg::GCALL_ADDR)
                    begin
                        dec_ack = 1'b1;
                        dec_state = color_i2c_pkg::ST_GCALL;
                    end
                    else if (rx_byte[7:3] == color_i2c_pkg::HS_CODE_PREFIX)
                    begin
                        dec_hs = 1'b1;
                        dec_state = color_i2c_pkg::ST_IGNORE;
                    end
                    else
                        dec_state = color_i2c_pkg::ST_IGNORE;
                end
                color_i2c_pkg::ST_WRITE:
                begin
                    case (byte_idx)
                        2'h0:
                        begin
                            dec_ptr_load = 1'b1;
                            dec_ack = 1'b1;
                        end
                        2'h1:
                            dec_ack = 1'b1;
                        default:
                        begin
                            // no room: refuse the byte rather than lose the word
                            dec_ack = buf_room;
                            dec_push = buf_room;
                        end
                    endcase
                end
                color_i2c_pkg::ST_GCALL:
                begin
                    dec_ack = (rx_byte == color_i2c_pkg::GC_RESET_CMD);
                    dec_gc = dec_ack;
                    dec_state = color_i2c_pkg::ST_IGNORE;
                end
                default:
                    dec_state = state;
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N || timeout_evt || stop_evt)
        begin
            state <= color_i2c_pkg::ST_IDLE;
            bit_cnt <= '0;
            sda_oe <= 1'b0;
            ack_pend <= 1'b0;
            first_rd <= 1'b0;
            byte_idx <= '0;
            if (!I_RESET_N)
            begin
                shreg <= '0;
                tx <= color_i2c_pkg::READ_PAD;
                rd_lo <= color_i2c_pkg::READ_PAD;
                msb <= '0;
            end
        end
        else if (start_evt)
        begin
            // repeated start also lands here and aborts any byte in flight
            state <= color_i2c_pkg::ST_ADDR;
            bit_cnt <= '0;
            byte_idx <= '0;
            sda_oe <= 1'b0;
            ack_pend <= 1'b0;
        end
        else
        begin
            if (bit_evt && state != color_i2c_pkg::ST_IDLE)
            begin
                if (bit_cnt < color_i2c_pkg::BYTE_DONE)
                begin
                    shreg <= rx_byte;
                    tx <= {tx[6:0], 1'b1};
                    bit_cnt <= bit_cnt + 4'h1;
                end
                else if (bit_cnt == color_i2c_pkg::BYTE_DONE)
                begin
                    bit_cnt <= color_i2c_pkg::ACK_DONE;
                    if (state == color_i2c_pkg::ST_READ)
                    begin
                        if (first_rd)
                            first_rd <= 1'b0;
                        else if (bit_val)
                            state <= color_i2c_pkg::ST_IGNORE;
                        else
                        begin
                            tx <= rd_lo;
                            rd_lo <= color_i2c_pkg::READ_PAD;
                        end
                    end
                end
                if (byte_end)
                begin
                    state <= dec_state;
                    ack_pend <= dec_ack;
                    if (state == color_i2c_pkg::ST_WRITE)
                    begin
                        if (byte_idx == 2'h1)
                            msb <= rx_byte;
                        if (byte_idx != 2'h2 || dec_ack)
                            byte_idx <= (byte_idx == 2'h1) ? 2'h2 : 2'h1;
                    end
                    if (dec_rd_load)
                    begin
                        tx <= I_RD_DATA[15:8];
                        rd_lo <= I_RD_DATA[7:0];
                        first_rd <= 1'b1;
                    end
                end
            end
            if (scl_fall && state != color_i2c_pkg::ST_IDLE)
            begin
                if (bit_cnt == color_i2c_pkg::BYTE_DONE)
                    sda_oe <= ack_pend;
                else
                begin
                    if (bit_cnt == color_i2c_pkg::ACK_DONE)
                        bit_cnt <= '0;
                    sda_oe <= (state == color_i2c_pkg::ST_READ) & ~tx[7];
                end
            end
        end
    end

    // pointer, general-call pulse and high-speed flag
    logic gc_pulse, hs_mode, sda_o;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N || dec_gc)
            ptr <= color_i2c_pkg::PTR_RESET;
        else if (dec_ptr_load)
            ptr <= rx_byte;
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        gc_pulse <= I_RESET_N & dec_gc;
        sda_o <= 1'b0;
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N || stop_evt || timeout_evt)
            hs_mode <= 1'b0;
        else if (dec_hs)
            hs_mode <= 1'b1;
    end

    // two-entry write buffer: head drives the ports, spare takes the overflow
    logic out_valid, spare_valid, pop;
    logic [BUF_W-1:0] out_word, spare_word, push_word;

    assign pop = out_valid & I_WR_READY;
    assign buf_room = ~spare_valid;
    assign push_word = {ptr, msb, rx_byte};

    always_ff @(posedge I_CLK_SYS)
    begin
        if (!I_RESET_N)
        begin
            out_valid <= 1'b0;
            spare_valid <= 1'b0;
            out_word <= '0;
            spare_word <= '0;
        end
        else if (pop)
        begin
            out_valid <= spare_valid | dec_push;
            out_word <= spare_valid ? spare_word : push_word;
            spare_valid <= spare_valid & dec_push;
            if (spare_valid && dec_push)
                spare_word <= push_word;
        end
        else if (dec_push)
        begin
            if (!out_valid)
            begin
                out_valid <= 1'b1;
                out_word <= push_word;
            end
            else
            begin
                spare_valid <= 1'b1;
                spare_word <= push_word;
            end
        end
    end

    assign O_SDA_O = sda_o;
    assign O_SDA_OE = sda_oe;
    assign O_WR_VALID = out_valid;
    assign O_WR_PTR = out_word[BUF_W-1:color_i2c_pkg::REG_W];
    assign O_WR_DATA = out_word[color_i2c_pkg::REG_W-1:0];
    assign O_RD_PTR = ptr;
    assign O_GC_RESET = gc_pulse;
    assign O_HS_MODE = hs_mode;

endmodule : color_i2c_target

`default_nettype wire

// ### color_i2c_pkg.sv
/*
 * Shared constants and types for the colour sensor two-wire target port:
 * bus rates, lockup timeout, strap addresses, special bus codes and states.
 * Assumes a 40 MHz system clock; all users reference names as package::name.
 */
`default_nettype none

package color_i2c_pkg;

    // system clock and the bus rates the port is built for
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int RATE_STD_HZ = 100_000;
    localparam int RATE_FAST_HZ = 400_000;
    localparam int RATE_HS_HZ = 2_600_000;

    // clock-low lockup timeout; a longest time, so the count rounds down
    localparam int TIMEOUT_MS = 28;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (SYS_CLK_HZ / 1000);
    localparam int TIMEOUT_W = 21;

    // 7-bit target addresses by strap connection
    localparam logic [6:0] ADDR_GND = 7'h44;
    localparam logic [6:0] ADDR_VDD = 7'h45;
    localparam logic [6:0] ADDR_SDA = 7'h46;
    localparam logic [6:0] ADDR_SCL = 7'h45;

    // special first and second bytes
    localparam logic [7:0] GCALL_ADDR = 8'h00;
    localparam logic [7:0] GC_RESET_CMD = 8'h06;
    localparam logic [4:0] HS_CODE_PREFIX = 5'h01;

    // widths and fixed values of the register path
    localparam int PTR_W = 8;
    localparam int REG_W = 16;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] READ_PAD = 8'hFF;

    // bit counter marks within one transfer unit
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BYTE_DONE = 4'h8;
    localparam logic [3:0] ACK_DONE = 4'h9;

    typedef enum logic [1:0] {STRAP_GND, STRAP_VDD, STRAP_SDA, STRAP_SCL} strap_t;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WRITE, ST_READ, ST_GCALL, ST_IGNORE} state_t;

    function automatic logic [6:0] strap_address(input strap_t s);
    begin
        case (s)
            STRAP_GND: strap_address = ADDR_GND;
            STRAP_VDD: strap_address = ADDR_VDD;
            STRAP_SDA: strap_address = ADDR_SDA;
            default: strap_address = ADDR_SCL;
        endcase
    end
    endfunction : strap_address

endpackage : color_i2c_pkg

`default_nettype wire

// ### unused_placeholder_never.sv
/*
 * Intentionally empty compilation unit.
 * Assumes nothing.
 */
`default_nettype none
`default_nettype wire

// ### color_i2c_assertions.sv
/*
 * Concurrent checks on the two-wire target port, system clock domain only.
 * Assumes it is bound to color_i2c_target and sees its ports by name.
 */
`default_nettype none

module color_i2c_assertions #(
    parameter int TIMEOUT_CYC = 200
) (
    // clock, reset and bus
    input wire logic I_CLK_SYS,
    input wire logic I_RESET_N,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic O_SDA_O,
    input wire logic O_SDA_OE,
    // write stream and status
    input wire logic I_WR_READY,
    input wire logic O_WR_VALID,
    input wire logic [7:0] O_WR_PTR,
    input wire logic [15:0] O_WR_DATA,
    input wire logic [7:0] O_RD_PTR,
    input wire logic O_GC_RESET,
    input wire logic O_HS_MODE
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RESET_N);

    // raw low time; the port sees scl a few cycles late, hence the margin below
    int low_cnt = 0;
    always_ff @(posedge I_CLK_SYS)
    begin
        low_cnt <= I_SCL ? 0 : low_cnt + 1;
    end

    sda_low_only_a: assert property (O_SDA_O == 1'b0)
        else $error("sda data output not zero");
    word_hold_a: assert property (O_WR_VALID && !I_WR_READY |=> O_WR_VALID && $stable(O_WR_PTR) && $stable(O_WR_DATA))
        else $error("write word changed while stalled");
    gc_pulse_a: assert property (O_GC_RESET |=> !O_GC_RESET)
        else $error("general call reset longer than one cycle");
    gc_ptr_a: assert property (O_GC_RESET |-> ##[0:2] O_RD_PTR == 8'h00)
        else $error("pointer not cleared by general call");
    oe_scl_low_a: assert property ($changed(O_SDA_OE) |-> !I_SCL)
        else $error("sda drive changed while scl high");
    hs_stop_a: assert property ($rose(I_SDA) && I_SCL && $past(I_SCL) |-> ##[1:6] !O_HS_MODE)
        else $error("high speed mode kept after stop");
    hs_no_ack_a: assert property ($rose(O_HS_MODE) |-> !O_SDA_OE [*8] ##1 !O_SDA_OE [*8])
        else $error("high speed code acknowledged");
    lockup_a: assert property (low_cnt > TIMEOUT_CYC + 8 |-> !O_SDA_OE && !O_HS_MODE)
        else $error("bus state kept after scl lockup");

endmodule : color_i2c_assertions

`default_nettype wire

// ### color_i2c_ctrl_model.sv
/*
 * Bus controller model: makes scl from its own 32 ns tick and pulls sda low.
 * Assumes a pull-up resolves sda outside; the bench calls its tasks.
 */
`default_nettype none

module color_i2c_ctrl_model (
    // bus side
    output logic o_scl,
    output logic o_sda_low,
    input wire logic i_sda
);
    timeunit 1ns;
    timeprecision 100ps;

    logic tick = 1'b0;

    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        #7;
        forever #16 tick = ~tick;
    end

    // phases of 8 ticks: the port needs 8 system cycles per scl phase
    task automatic wait_t(input int n);
        repeat (n) @(posedge tick);
    endtask : wait_t

    task automatic start_c();
        wait_t(4);
        o_sda_low = 1'b0;
        wait_t(4);
        o_scl = 1'b1;
        wait_t(8);
        o_sda_low = 1'b1;
        wait_t(8);
        o_scl = 1'b0;
    endtask : start_c

    task automatic stop_c();
        wait_t(4);
        o_sda_low = 1'b1;
        wait_t(4);
        o_scl = 1'b1;
        wait_t(8);
        o_sda_low = 1'b0;
        wait_t(8);
    endtask : stop_c

    task automatic bit_c(input logic v, output logic r);
        wait_t(4);
        o_sda_low = ~v;
        wait_t(4);
        o_scl = 1'b1;
        wait_t(8);
        r = i_sda;
        o_scl = 1'b0;
    endtask : bit_c

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_c(b[i], r);
        bit_c(1'b1, r);
        ack = ~r;
    endtask : wr_byte

    task automatic rd_byte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_c(1'b1, r);
            b[i] = r;
        end
        bit_c(nack, r);
    endtask : rd_byte

endmodule : color_i2c_ctrl_model

`default_nettype wire

// ### testbench.sv
/*
 * Self-checking bench for the two-wire target port with a controller model.
 * Assumes a small lockup count; scenarios run in order as tasks.
 */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic wr_ready = 1'b0;
    logic [15:0] rd_data = 16'h0000;
    logic [1:0] strap = 2'h0;
    logic gc_seen = 1'b0;
    wire logic scl;
    wire logic sda_low;
    wire logic sda_oe;
    wire logic sda;
    wire logic addr_pin;
    wire logic wr_valid;
    wire logic [7:0] wr_ptr;
    wire logic [15:0] wr_data;
    wire logic [7:0] rd_ptr;
    wire logic gc_reset;
    wire logic hs_mode;
    int err_total = 0;
    int n_checks = 0;
    logic [23:0] words[$];

    // open drain with pull-up; strap 2 ties the address pin to sda, strap 3 to scl
    assign sda = (sda_low || sda_oe) ? 1'b0 : 1'b1;
    assign addr_pin = strap == 2'h0 ? 1'b0 : strap == 2'h1 ? 1'b1 : strap == 2'h2 ? sda : scl;

    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    color_i2c_ctrl_model ctrl (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));

    color_i2c_target #(.TIMEOUT_CYC(200)) color_i2c_target_i (
        .I_CLK_SYS(clk_sys), .I_RESET_N(reset_n), .I_SCL(scl), .I_SDA(sda), .O_SDA_O(),
        .O_SDA_OE(sda_oe), .I_ADDR_PIN(addr_pin), .O_WR_VALID(wr_valid), .I_WR_READY(wr_ready),
        .O_WR_PTR(wr_ptr), .O_WR_DATA(wr_data), .O_RD_PTR(rd_ptr), .I_RD_DATA(rd_data),
        .O_GC_RESET(gc_reset), .O_HS_MODE(hs_mode));

    always @(posedge clk_sys)
    begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            words.push_back({wr_ptr, wr_data});
        if (gc_reset === 1'b1)
            gc_seen <= 1'b1;
    end

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic wb(input logic [7:0] b, input logic exp_ack);
        logic a;
        ctrl.wr_byte(b, a);
        chk(a, exp_ack);
    endtask : wb

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    task automatic t_write();
        @(posedge clk_sys);
        wr_ready <= 1'b1;
        words.delete();
        ctrl.start_c();
        wb(8'h88, 1'b1);
        wb(8'h5A, 1'b1);
        wb(8'hC3, 1'b1);
        wb(8'h3C, 1'b1);
        ctrl.stop_c();
        chk(rd_ptr, 8'h5A);
        chk(24'(words.size()), 24'h000001);
        chk(words[0], 24'h5AC33C);
    endtask : t_write

    task automatic t_read();
        logic [7:0] b;
        @(posedge clk_sys);
        rd_data <= 16'hA55A;
        ctrl.start_c();
        wb(8'h89, 1'b1);
        ctrl.rd_byte(1'b0, b);
        chk(b, 8'hA5);
        ctrl.rd_byte(1'b1, b);
        chk(b, 8'h5A);
        ctrl.stop_c();
        chk(rd_ptr, 8'h5A);
    endtask : t_read

    task automatic t_strap();
        logic [6:0] own[4] = '{7'h44, 7'h45, 7'h46, 7'h45};
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk_sys);
            strap <= s[1:0];
            repeat (8) @(posedge clk_sys);
            ctrl.start_c();
            wb({own[(s + 1) % 4], 1'b0}, 1'b0);
            wb(8'hFF, 1'b0);
            ctrl.stop_c();
            ctrl.start_c();
            wb({own[s], 1'b0}, 1'b1);
            ctrl.stop_c();
        end
    endtask : t_strap

    // third word meets a full two-entry buffer and must be refused
    task automatic t_stall();
        @(posedge clk_sys);
        strap <= 2'h0;
        wr_ready <= 1'b0;
        words.delete();
        ctrl.start_c();
        wb(8'h88, 1'b1);
        wb(8'h12, 1'b1);
        for (int k = 0; k < 3; k++)
        begin
            wb(8'hB0 + k[7:0], 1'b1);
            wb(8'h40 + k[7:0], k < 2);
        end
        ctrl.stop_c();
        chk(24'(words.size()), 24'h000000);
        @(posedge clk_sys);
        wr_ready <= 1'b1;
        repeat (6) @(posedge clk_sys);
        chk(24'(words.size()), 24'h000002);
        chk(words[0], 24'h12B040);
        chk(words[1], 24'h12B141);
        chk(wr_valid, 1'b0);
    endtask : t_stall

    task automatic t_gcall();
        @(posedge clk_sys);
        gc_seen <= 1'b0;
        ctrl.start_c();
        wb(8'h00, 1'b1);
        wb(8'h06, 1'b1);
        ctrl.stop_c();
        chk(gc_seen, 1'b1);
        chk(rd_ptr, 8'h00);
    endtask : t_gcall

    // the lockup case holds scl low while the port drives a read bit of 0
    task automatic t_hs();
        @(posedge clk_sys);
        rd_data <= 16'h0000;
        ctrl.start_c();
        wb(8'h0B, 1'b0);
        chk(hs_mode, 1'b1);
        ctrl.start_c();
        wb(8'h88, 1'b1);
        ctrl.stop_c();
        chk(hs_mode, 1'b0);
        ctrl.start_c();
        wb(8'h08, 1'b0);
        ctrl.start_c();
        wb(8'h89, 1'b1);
        repeat (260) @(posedge clk_sys);
        chk(sda_oe, 1'b0);
        chk(hs_mode, 1'b0);
        ctrl.stop_c();
    endtask : t_hs

    initial
    begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        t_write();
        t_read();
        t_strap();
        t_stall();
        t_gcall();
        t_hs();
        tally_and_finish();
    end

    initial
    begin
        #1000000;
        err_total++;
        tally_and_finish();
    end

endmodule : testbench

bind color_i2c_target color_i2c_assertions #(.TIMEOUT_CYC(TIMEOUT_CYC)) color_i2c_assertions_i (
    .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA_O(O_SDA_O),
    .O_SDA_OE(O_SDA_OE), .I_WR_READY(I_WR_READY), .O_WR_VALID(O_WR_VALID), .O_WR_PTR(O_WR_PTR),
    .O_WR_DATA(O_WR_DATA), .O_RD_PTR(O_RD_PTR), .O_GC_RESET(O_GC_RESET), .O_HS_MODE(O_HS_MODE));

`default_nettype wire
